// File: design/csbc_defines.svh
// Constants for the chip-select and bus-control pin block.
`ifndef CSBC_DEFINES_SVH
`define CSBC_DEFINES_SVH
`define CSBC_ADDR_W 20
`define CSBC_NUM_MID 4
`define CSBC_NUM_PER 7
`define CSBC_REFRESH_HOLDOFF_NS 10
`define CSBC_CLK_NS 5
`define CSBC_REFRESH_HOLDOFF_CYC ((`CSBC_REFRESH_HOLDOFF_NS + `CSBC_CLK_NS - 1) / `CSBC_CLK_NS)
`endif

// File: design/csbc_pkg.sv
// Types for the chip-select and bus-control pin block.
package csbc_pkg;
   typedef enum logic [1:0] {
      CSBC_OWN,
      CSBC_GRANTED,
      CSBC_RECLAIM
   } csbc_hold_e;
endpackage

// File: design/csbc_range_match.sv
// Address window comparator for one chip-select output.
`timescale 1ns/100ps
`default_nettype none
`include "csbc_defines.svh"
module csbc_range_match (
   input wire logic [`CSBC_ADDR_W-1:0] addr,
   input wire logic [`CSBC_ADDR_W-1:0] base,
   input wire logic [`CSBC_ADDR_W-1:0] limit,
   input wire logic enable,
   output logic hit
);
   always_comb begin
      hit = enable && (addr >= base) && (addr <= limit);
   end
endmodule
`default_nettype wire

// File: design/csbc_top.sv
// Chip-select, transceiver control and bus hold logic of the processor pins.
// How it works
// (RL1) Another master raises hold request; we answer with hold acknowledge and float.
// (RL2) In enhanced mode a pending refresh during hold drops hold acknowledge.
// (RL3) The external master then drops hold request so refresh can run.
// (RL4) Upper select goes low inside its upper window; stays driven in hold.
// (RL5) Lower select goes low inside its lower window; stays driven in hold.
// (RL6) Both upper and lower low at reset release enters test mode, all float.
// (RL7) Upper and lower select pins have pull-ups enabled only during reset.
// (RL8) Four mid-range selects go low inside their windows; driven in hold.
// (RL9) Enhanced mode: mid select 0 is the coprocessor transfer request input.
// (RL10) Enhanced mode: mid select 3 becomes coprocessor select for coprocessor cycles.
// (RL11) Enhanced mode: mid select 1 is the coprocessor error input.
// (RL12) Mid selects 0 and 1 have pull-ups active during reset.
// (RL13) Peripheral selects 0 to 4 go low in their I/O or memory window.
// (RL14) Peripheral selects 5 and 6 may carry latched A1 and A2, held in hold.
// (RL15) Direction low on reads, high on writes; floats in hold and reset.
// (RL16) Transceiver enable low during every memory and I/O access.
// (RL17) Transceiver enable high whenever the direction output changes.
// (RL18) Enable driven high one clock in reset then floats; floats in hold.
// (RL19) Each select other than mid select 3 in enhanced mode and latched peripheral selects 5 and 6 is high outside its window and low only during a match.
`timescale 1ns/100ps
`default_nettype none
`include "csbc_defines.svh"
module csbc_top (
   input wire logic clk,
   input wire logic srst,
   input wire logic enhanced_mode,
   input wire logic hold_request,
   input wire logic refresh_pending,
   input wire logic cycle_active,
   input wire logic cycle_is_mem,
   input wire logic cycle_is_write,
   input wire logic cycle_is_coproc,
   input wire logic [`CSBC_ADDR_W-1:0] cycle_addr,
   input wire logic [`CSBC_ADDR_W-1:0] upper_base,
   input wire logic [`CSBC_ADDR_W-1:0] lower_limit,
   input wire logic [`CSBC_NUM_MID*`CSBC_ADDR_W-1:0] mid_base,
   input wire logic [`CSBC_NUM_MID*`CSBC_ADDR_W-1:0] mid_limit,
   input wire logic [`CSBC_NUM_PER*`CSBC_ADDR_W-1:0] per_base,
   input wire logic [`CSBC_NUM_PER*`CSBC_ADDR_W-1:0] per_limit,
   input wire logic per_in_mem_space,
   input wire logic per_latched_addr_mode,
   input wire logic upper_select_pin_in,
   input wire logic lower_select_pin_in,
   input wire logic midrange_select0_pin_in,
   input wire logic midrange_select1_pin_in,
   output logic upper_mem_select_n,
   output logic lower_mem_select_n,
   output logic [`CSBC_NUM_MID-1:0] midrange_mem_select_n,
   output logic [`CSBC_NUM_MID-1:0] midrange_select_oe,
   output logic coproc_transfer_request,
   output logic coproc_error,
   output logic [4:0] periph_select_n,
   output logic periph_select5_or_latched_addr1,
   output logic periph_select6_or_latched_addr2,
   output logic xcvr_direction,
   output logic xcvr_direction_oe,
   output logic xcvr_enable_n,
   output logic xcvr_enable_oe,
   output logic hold_acknowledge,
   output logic select_pullup_en,
   output logic select_oe,
   output logic test_mode
);
   // Pin samplers: two flip-flops per asynchronous input.
   logic [3:0] pin_s1_reg, pin_s2_reg;
   logic hreq_s1_reg, hreq_s2_reg;
   always_ff @(posedge clk) begin
      pin_s1_reg <= {midrange_select1_pin_in, midrange_select0_pin_in,
                     lower_select_pin_in, upper_select_pin_in};
      pin_s2_reg <= pin_s1_reg;
      hreq_s1_reg <= hold_request;
      hreq_s2_reg <= hreq_s1_reg;
   end

   // Test-mode strap caught at the clock after reset releases.
   // The strap is read only once, so later activity on the select pins cannot leave test mode.
   logic in_reset_reg, in_reset_next, test_reg, test_next;
   always_comb begin
      in_reset_next = srst;
      test_next = test_reg;
      if (in_reset_reg && !srst) begin
         test_next = !pin_s2_reg[0] && !pin_s2_reg[1]; // RL6
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         test_reg <= 1'b0;
      end else begin
         test_reg <= test_next;
      end
      in_reset_reg <= in_reset_next;
   end

   // Hold arbitration.
   csbc_pkg::csbc_hold_e hstate_reg, hstate_next;
   always_comb begin
      hstate_next = hstate_reg;
      case (hstate_reg)
         csbc_pkg::CSBC_OWN: begin
            if (hreq_s2_reg && !cycle_active) begin
               hstate_next = csbc_pkg::CSBC_GRANTED; // RL1
            end
         end
         csbc_pkg::CSBC_GRANTED: begin
            if (!hreq_s2_reg) begin
               hstate_next = csbc_pkg::CSBC_OWN;
            end else if (enhanced_mode && refresh_pending) begin
               hstate_next = csbc_pkg::CSBC_RECLAIM; // RL2
            end
         end
         default: begin
            if (!hreq_s2_reg) begin
               hstate_next = csbc_pkg::CSBC_OWN; // RL3
            end
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         hstate_reg <= csbc_pkg::CSBC_OWN;
      end else begin
         hstate_reg <= hstate_next;
      end
   end
   wire logic bus_held = (hstate_reg != csbc_pkg::CSBC_OWN);

   // Window comparators.
   localparam int NW = 2 + `CSBC_NUM_MID + `CSBC_NUM_PER;
   localparam logic [`CSBC_ADDR_W-1:0] ADDR_TOP = '1;
   logic [NW-1:0] hit;
   csbc_range_match u_upper (
      .addr(cycle_addr), .base(upper_base), .limit(ADDR_TOP),
      .enable(cycle_is_mem), .hit(hit[0])); // RL4
   csbc_range_match u_lower (
      .addr(cycle_addr), .base('0), .limit(lower_limit),
      .enable(cycle_is_mem), .hit(hit[1])); // RL5
   genvar g;
   generate
      for (g = 0; g < `CSBC_NUM_MID; g++) begin : g_mid
         csbc_range_match u_mid (
            .addr(cycle_addr),
            .base(mid_base[g*`CSBC_ADDR_W +: `CSBC_ADDR_W]),
            .limit(mid_limit[g*`CSBC_ADDR_W +: `CSBC_ADDR_W]),
            .enable(cycle_is_mem), .hit(hit[2+g])); // RL8
      end
      for (g = 0; g < `CSBC_NUM_PER; g++) begin : g_per
         csbc_range_match u_per (
            .addr(cycle_addr),
            .base(per_base[g*`CSBC_ADDR_W +: `CSBC_ADDR_W]),
            .limit(per_limit[g*`CSBC_ADDR_W +: `CSBC_ADDR_W]),
            .enable(cycle_is_mem == per_in_mem_space),
            .hit(hit[2+`CSBC_NUM_MID+g])); // RL13
      end
   endgenerate

   // Select and transceiver outputs.
   logic [NW-1:0] sel_n_reg, sel_n_next;
   logic [1:0] latch_reg, latch_next;
   logic dir_reg, dir_next, den_n_reg, den_n_next, hold_acknowledge_reg, hold_acknowledge_next;
   logic den_oe_reg, den_oe_next, rst_pulse_reg, rst_pulse_next;
   logic active;
   always_comb begin
      active = cycle_active && !bus_held;
      sel_n_next = ~(hit & {NW{active}}); // RL19
      if (enhanced_mode) begin
         sel_n_next[5] = !(active && cycle_is_coproc); // RL10
      end
      latch_next = latch_reg;
      if (active) begin
         latch_next = cycle_addr[2:1]; // RL14
      end
      dir_next = dir_reg;
      if (active) begin
         dir_next = cycle_is_write; // RL15
      end
      // The enable stays high in the cycle the direction flips, so the transceiver never fights.
      den_n_next = !(active && (dir_next == dir_reg)); // RL16 RL17
      hold_acknowledge_next = (hstate_next == csbc_pkg::CSBC_GRANTED);
      rst_pulse_next = srst && !in_reset_reg;
      den_oe_next = !srst && !bus_held && !test_reg; // RL18
      if (srst && !in_reset_reg) begin
         den_oe_next = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         sel_n_reg <= '1;
         latch_reg <= 2'h0;
         dir_reg <= 1'b0;
         den_n_reg <= 1'b1;
         hold_acknowledge_reg <= 1'b0;
      end else begin
         sel_n_reg <= sel_n_next;
         latch_reg <= latch_next;
         dir_reg <= dir_next;
         den_n_reg <= den_n_next;
         hold_acknowledge_reg <= hold_acknowledge_next;
      end
      den_oe_reg <= den_oe_next;
      rst_pulse_reg <= rst_pulse_next;
   end

   // Registered pin drivers.
   always_ff @(posedge clk) begin
      if (srst) begin
         upper_mem_select_n <= 1'b1;
         lower_mem_select_n <= 1'b1;
         midrange_mem_select_n <= 4'hF;
         midrange_select_oe <= 4'h0;
         coproc_transfer_request <= 1'b0;
         coproc_error <= 1'b0;
         periph_select_n <= 5'h1F;
         periph_select5_or_latched_addr1 <= 1'b1;
         periph_select6_or_latched_addr2 <= 1'b1;
         xcvr_direction <= 1'b0;
         xcvr_direction_oe <= 1'b0; // RL15
         hold_acknowledge <= 1'b0;
         select_pullup_en <= 1'b1; // RL7 RL12
         select_oe <= 1'b0;
         test_mode <= 1'b0;
      end else begin
         upper_mem_select_n <= sel_n_reg[0];
         lower_mem_select_n <= sel_n_reg[1];
         midrange_mem_select_n <= sel_n_reg[5:2];
         midrange_select_oe <= test_reg ? 4'h0 :
                               (enhanced_mode ? 4'hC : 4'hF); // RL9 RL11
         coproc_transfer_request <= enhanced_mode && pin_s2_reg[2]; // RL9
         coproc_error <= enhanced_mode && !pin_s2_reg[3]; // RL11
         periph_select_n <= sel_n_reg[10:6];
         periph_select5_or_latched_addr1 <= per_latched_addr_mode ? latch_reg[0] :
                                            sel_n_reg[11]; // RL14
         periph_select6_or_latched_addr2 <= per_latched_addr_mode ? latch_reg[1] :
                                            sel_n_reg[12]; // RL14
         xcvr_direction <= dir_reg;
         xcvr_direction_oe <= !bus_held && !test_reg; // RL15
         hold_acknowledge <= hold_acknowledge_reg; // RL1 RL2
         select_pullup_en <= 1'b0;
         select_oe <= !test_reg; // RL6
         test_mode <= test_reg;
      end
      xcvr_enable_n <= (srst || rst_pulse_reg) ? 1'b1 : den_n_reg; // RL18
      xcvr_enable_oe <= den_oe_reg;
   end

   AST_DEN_HIGH_ON_DIR_CHANGE: assert property (@(posedge clk) disable iff (srst)
      (dir_reg != $past(dir_reg)) |-> den_n_reg) // RL17
      else $error("enable low while direction changed");
   AST_HOLD_ACKNOWLEDGE_DROPS_FOR_REFRESH: assert property (@(posedge clk) disable iff (srst)
      (hstate_reg == csbc_pkg::CSBC_RECLAIM) |=> ##1 !hold_acknowledge) // RL2
      else $error("hold acknowledge kept during refresh reclaim");
   AST_NO_SELECT_IN_HOLD: assert property (@(posedge clk) disable iff (srst)
      bus_held |=> sel_n_reg == '1) // RL19
      else $error("select asserted while bus held");
   AST_DIR_FLOATS_IN_HOLD: assert property (@(posedge clk) disable iff (srst)
      bus_held && !$past(srst) |=> !xcvr_direction_oe) // RL15
      else $error("direction driven in hold");
   AST_DEN_IDLE_HIGH: assert property (@(posedge clk) disable iff (srst)
      !cycle_active |=> den_n_reg) // RL16
      else $error("enable low without access");
   AST_SEL_STAY_DRIVEN: assert property (@(posedge clk) disable iff (srst)
      !test_reg |=> select_oe) // RL4 RL5 RL8 RL13
      else $error("selects floated outside test mode");
   AST_TEST_FLOATS: assert property (@(posedge clk) disable iff (srst)
      test_reg |=> !select_oe && midrange_select_oe == 4'h0) // RL6
      else $error("pins driven in test mode");
   AST_HOLD_ACKNOWLEDGE_NEEDS_REQ: assert property (@(posedge clk) disable iff (srst)
      hold_acknowledge |-> $past(hreq_s2_reg, 2)) // RL1
      else $error("hold acknowledge without request");
   // Further checks on the pin rules.
   AST_DEN_FLOATS_IN_HOLD: assert property (@(posedge clk) disable iff (srst)
      bus_held |=> ##1 !xcvr_enable_oe) // RL18
      else $error("enable driven in hold");
   AST_PULLUP_ONLY_IN_RESET: assert property (@(posedge clk)
      (srst |=> select_pullup_en) and (!srst |=> !select_pullup_en)) // RL7 RL12
      else $error("pull-up enable wrong for reset state");
   AST_COPROC_SELECT_ONLY: assert property (@(posedge clk) disable iff (srst)
      enhanced_mode && !cycle_is_coproc |=> sel_n_reg[5]) // RL10
      else $error("coprocessor select without coprocessor cycle");
   AST_LATCH_HELD_IN_HOLD: assert property (@(posedge clk) disable iff (srst)
      bus_held |=> latch_reg == $past(latch_reg)) // RL14
      else $error("latched address changed in hold");
   AST_UPPER_LOW_ON_MATCH: assert property (@(posedge clk) disable iff (srst)
      active && hit[0] |=> !sel_n_reg[0]) // RL4
      else $error("upper select missed a match");
   AST_LOWER_LOW_ON_MATCH: assert property (@(posedge clk) disable iff (srst)
      active && hit[1] |=> !sel_n_reg[1]) // RL5
      else $error("lower select missed a match");
   AST_DIR_FOLLOWS_WRITE: assert property (@(posedge clk) disable iff (srst)
      active |=> dir_reg == $past(cycle_is_write)) // RL15
      else $error("direction does not follow the access");
   AST_TEST_MODE_KEPT: assert property (@(posedge clk) disable iff (srst)
      test_reg |=> test_reg) // RL6
      else $error("test mode left without reset");
   AST_ENABLE_PULSE_IN_RESET: assert property (@(posedge clk)
      srst && !in_reset_reg |=> den_oe_reg) // RL18
      else $error("enable not driven on reset entry");
   AST_HOLD_ACKNOWLEDGE_DROPS_ON_RELEASE: assert property (@(posedge clk) disable iff (srst)
      !hreq_s2_reg |=> ##1 !hold_acknowledge) // RL1
      else $error("hold acknowledge kept after release");
endmodule
`default_nettype wire

// File: bench/csbc_partner.sv
// Model of an outside bus master that borrows the local bus.
`timescale 1ns/100ps
`default_nettype none
module csbc_partner (
   input wire logic clk,
   input wire logic want,
   input wire logic hold_acknowledge,
   output logic hold_request
);
   logic ack_q = 1'b0;
   logic gave_back = 1'b0;
   always @(posedge clk) begin
      ack_q <= hold_acknowledge;
      if (!want) begin
         gave_back <= 1'b0;
      end else if (ack_q && !hold_acknowledge) begin
         gave_back <= 1'b1;
      end
      hold_request <= want && !gave_back && !(ack_q && !hold_acknowledge);
   end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the chip-select and bus-control block.
`timescale 1ns/100ps
`default_nettype none
`include "csbc_defines.svh"
module testbench;
   logic clk = 0, srst = 1, enh = 0, want = 0, rfp = 0, act = 0, mem = 0, wr = 0, cp = 0;
   logic [19:0] addr = 0;
   logic [79:0] mb, ml;
   logic [139:0] pb, pl;
   logic pmem = 1, plat = 0, upin = 1, lpin = 1, m0pin = 1, m1pin = 1;
   logic hreq;
   logic up, lo, ctr, cer, p5, p6, dir, dir_oe, en, en_oe, hack, pu, soe, tm;
   logic [3:0] mid, mid_oe;
   logic [4:0] per;
   int num_errors = 0, cmp_count = 0, ticks = 0;
   always #2.5 clk = ~clk;
   csbc_partner u_csbc_partner (.clk(clk), .want(want), .hold_acknowledge(hack),
      .hold_request(hreq));
   csbc_top u_csbc_top (.clk(clk), .srst(srst), .enhanced_mode(enh), .hold_request(hreq),
      .refresh_pending(rfp), .cycle_active(act), .cycle_is_mem(mem), .cycle_is_write(wr),
      .cycle_is_coproc(cp), .cycle_addr(addr), .upper_base(20'hF0000),
      .lower_limit(20'h0FFFF), .mid_base(mb), .mid_limit(ml), .per_base(pb),
      .per_limit(pl), .per_in_mem_space(pmem), .per_latched_addr_mode(plat),
      .upper_select_pin_in(upin), .lower_select_pin_in(lpin),
      .midrange_select0_pin_in(m0pin), .midrange_select1_pin_in(m1pin),
      .upper_mem_select_n(up), .lower_mem_select_n(lo), .midrange_mem_select_n(mid),
      .midrange_select_oe(mid_oe), .coproc_transfer_request(ctr), .coproc_error(cer),
      .periph_select_n(per), .periph_select5_or_latched_addr1(p5),
      .periph_select6_or_latched_addr2(p6), .xcvr_direction(dir),
      .xcvr_direction_oe(dir_oe), .xcvr_enable_n(en), .xcvr_enable_oe(en_oe),
      .hold_acknowledge(hack), .select_pullup_en(pu), .select_oe(soe), .test_mode(tm));
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic do_reset(input logic u, input logic l);
      srst <= 1'b1;
      upin <= u;
      lpin <= l;
      repeat (3) @(posedge clk);
      #1 chk({pu, up, lo, en_oe, dir_oe}, 5'h1C);
      @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      upin <= 1'b1;
      lpin <= 1'b1;
      #1 chk(pu, 1'b0);
   endtask
   task automatic cyc(input logic [19:0] a, input logic m, input logic w, input logic c);
      @(posedge clk);
      act <= 1'b1;
      addr <= a;
      mem <= m;
      wr <= w;
      cp <= c;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic idle();
      @(posedge clk);
      act <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({up, lo, mid, p6, p5, per}, 13'h1FFF);
   endtask
   task automatic t_decode();
      logic [19:0] at [6] = '{20'hF1234, 20'h01000, 20'h84010, 20'h20100, 20'h20280, 20'h50000};
      logic [12:0] ex [6] = '{13'h0FFF, 13'h17FF, 13'h1EFF, 13'h1FFB, 13'h1FDF, 13'h1FFF};
      for (int i = 0; i < 6; i++) begin
         cyc(at[i], 1'b1, i[0], 1'b0);
         chk({up, lo, mid, p6, p5, per}, ex[i]);
         chk({en, dir}, {1'b0, i[0]});
      end
      cyc(20'h20100, 1'b0, 1'b0, 1'b0);
      chk(per, 5'h1F);
      idle();
      $display("test decode done");
   endtask
   task automatic t_latched();
      plat <= 1'b1;
      cyc(20'h00002, 1'b1, 1'b0, 1'b0);
      chk({p6, p5}, 2'h1);
      @(posedge clk);
      act <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({up, lo, mid, p6, p5, per}, 13'h1FBF);
      want <= 1'b1;
      for (int i = 0; i < 20 && hack !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1 chk({hack, p6, p5, soe, up, dir_oe, en_oe}, 7'h5C);
      want <= 1'b0;
      plat <= 1'b0;
      repeat (8) @(posedge clk);
      $display("test latched hold done");
   endtask
   task automatic t_enhanced();
      enh <= 1'b1;
      m1pin <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk({mid_oe, ctr, cer}, 6'h33);
      cyc(20'h00100, 1'b0, 1'b1, 1'b1);
      chk({mid[3], en}, 2'h0);
      idle();
      want <= 1'b1;
      for (int i = 0; i < 20 && hack !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      rfp <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(hack, 1'b0);
      repeat (3) @(posedge clk);
      #1 chk({hreq, hack}, 2'h0);
      rfp <= 1'b0;
      want <= 1'b0;
      enh <= 1'b0;
      m1pin <= 1'b1;
      repeat (4) @(posedge clk);
      $display("test enhanced done");
   endtask
   task automatic t_testmode();
      do_reset(1'b0, 1'b0);
      chk({tm, soe, mid_oe, en_oe, dir_oe}, 8'h80);
      do_reset(1'b1, 1'b1);
      chk(tm, 1'b0);
      $display("test strap done");
   endtask
   always @(posedge clk) begin
      ticks++;
      if (ticks == 3000) begin
         num_errors++;
         print_verdict();
      end
   end
   initial begin
      for (int g = 0; g < 4; g++) begin
         mb[g*20 +: 20] = 20'h80000 + g * 20'h04000;
         ml[g*20 +: 20] = 20'h83FFF + g * 20'h04000;
      end
      for (int g = 0; g < 7; g++) begin
         pb[g*20 +: 20] = 20'h20000 + g * 20'h00080;
         pl[g*20 +: 20] = 20'h2007F + g * 20'h00080;
      end
      do_reset(1'b1, 1'b1);
      t_decode();
      t_latched();
      t_enhanced();
      t_testmode();
      print_verdict();
   end
endmodule
`default_nettype wire
